// File: test/cmi_client_model.sv
`timescale 1ns/1ps
`include "cmi_cfg.svh"
// ****************************************
// Supervisory client on the register bus
// ****************************************
module cmi_client_model (
	input  wire logic               i_clk,
	input  wire logic               i_ack,
	input  wire cmi_pkg::cmi_word_t i_rdata,
	output logic [15:0]             o_addr,
	output logic                    o_wr,
	output logic                    o_rd,
	output cmi_pkg::cmi_word_t      o_wdata
);
	import cmi_pkg::*;

	initial begin
		o_addr = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'h0000;
	end

	// Released bus shows the inverse of the last value
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic k);
		@(negedge i_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_addr = ~a;
		d = i_rdata;
		k = i_ack;
	endtask

	// Header words, code last so it starts the command
	task automatic header(input logic [15:0] code, input logic [15:0] cnt,
		input logic [15:0] dst, input logic [15:0] sec, input logic [31:0] pw);
		wr(`CMI_A_COUNT, cnt);
		wr(`CMI_A_DEST, dst);
		wr(`CMI_A_SEC, sec);
		wr(`CMI_A_PW_HI, (sec == 16'h0000) ? 16'h0000 : pw[31:16]);
		wr(`CMI_A_PW_LO, (sec == 16'h0000) ? 16'h0000 : pw[15:0]);
		wr(`CMI_A_CODE, code);
	endtask

	// Name parameters; returns the byte count
	task automatic name(input string s, output logic [15:0] cnt);
		int i;
		logic [7:0] hi;
		logic [7:0] lo;
		wr(`CMI_A_PARAM, `CMI_P_NAME_0);
		wr(`CMI_A_PARAM + 16'h0001, `CMI_P_NAME_1);
		wr(`CMI_A_PARAM + 16'h0002, `CMI_P_NAME_2);
		for (i = 0; i <= s.len(); i += 2) begin
			hi = (i < s.len()) ? s[i] : 8'h00;
			lo = (i + 1 < s.len()) ? s[i + 1] : 8'h00;
			wr(`CMI_A_PARAM + 16'(3 + i / 2), {hi, lo});
		end
		cnt = 16'(7 + s.len());
	endtask
endmodule

// File: test/test_cmi_command_unit.sv
`timescale 1ns/1ps
`include "cmi_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
// ****************************************
// Command unit bench
// ****************************************
module test_cmi_command_unit;
	import cmi_pkg::*;

	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [15:0] addr;
	logic        wr;
	logic        rd;
	cmi_word_t   wdata;
	cmi_word_t   rdata;
	logic        ack;
	logic        busy;
	logic [7:0]  result;
	logic [8:0]  valid_s;
	wire  [4:0]  pulses;
	logic        lock = 1'b0;
	logic        lost = 1'b0;
	logic [127:0] prof = {32'h0badcafe, 32'h00e9e9e9, 32'h0055aa11, 32'h12345678};
	int          err_count = 0;
	int          compares = 0;

	always #10 i_clk = ~i_clk;

	cmi_command_unit #(.CYC_PER_MS(10), .EXT_IFACE(1'b1)) dut_u (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_wdata(wdata), .i_front_lock(lock),
		.i_supply_lost(lost), .i_profile_pw(prof), .o_reg_rdata(rdata),
		.o_reg_ack(ack), .o_busy(busy), .o_result(result), .o_validity_s(valid_s),
		.o_alarm_reset(pulses[4]), .o_cradle_preset(pulses[3]),
		.o_regrease_preset(pulses[2]), .o_event_fetch(pulses[1]),
		.o_name_written(pulses[0]));

	cmi_client_model client_u (
		.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
		.o_rd(rd), .o_wdata(wdata));

	task automatic complete_run;
		$display("mismatches %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmd(input logic [15:0] c, input logic [15:0] n, input logic [15:0] d,
		input logic [15:0] s, input logic [31:0] pw, input logic [7:0] er,
		input logic [4:0] ep);
		int k;
		client_u.header(c, n, d, s, pw);
		`CHK(busy, 1'b1)
		k = 0;
		while (busy !== 1'b0 && k < 20) begin
			@(negedge i_clk);
			k++;
		end
		if (k == 20) begin
			err_count++;
			complete_run();
		end
		`CHK(result, er)
		`CHK(pulses, ep)
	endtask

	task automatic rchk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic k;
		client_u.rd(a, d, k);
		`CHK(k, 1'b1)
		`CHK(d, e)
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_get_time;
		lock = 1'b1;
		cmd(`CMI_C_GET_TIME, `CMI_N_GET_TIME, `CMI_D_MODULES, 0, 0, `CMI_R_OK, 0);
		rchk(`CMI_A_RES_MD, 16'h0101);
		rchk(`CMI_A_RES_YH, 16'h0000);
		cmd(`CMI_C_ALARM, 0, 0, 1, prof[31:0], `CMI_R_LOCKED, 0);
		cmd(`CMI_C_GET_TIME, 16'h000b, `CMI_D_MODULES, 0, 0, `CMI_R_HDR, 0);
		cmd(16'h0302, `CMI_N_GET_TIME, `CMI_D_MODULES, 0, 0, `CMI_R_UNKNOWN, 0);
	endtask

	task automatic t_set_time;
		client_u.wr(`CMI_A_PARAM, 16'h060f);
		client_u.wr(`CMI_A_PARAM + 16'h0001, 16'h170c);
		client_u.wr(`CMI_A_PARAM + 16'h0002, 16'h2238);
		client_u.wr(`CMI_A_PARAM + 16'h0003, 16'h0315);
		cmd(`CMI_C_SET_TIME, `CMI_N_SET_TIME, `CMI_D_MODULES, 0, 0, `CMI_R_OK, 0);
		lock = 1'b0;
		cmd(`CMI_C_GET_TIME, `CMI_N_GET_TIME, `CMI_D_MODULES, 0, 0, `CMI_R_OK, 0);
		rchk(`CMI_A_RES_MD, 16'h060f);
		rchk(`CMI_A_RES_YH, 16'h170c);
		rchk(`CMI_A_RES_MS, 16'h2238);
		cmd(`CMI_C_SET_TIME, 16'h0010, `CMI_D_MODULES, 0, 0, `CMI_R_HDR, 0);
	endtask

	task automatic t_name;
		logic [15:0] n;
		client_u.name("AB", n);
		cmd(`CMI_C_NAME, n, `CMI_D_NAME, 0, 0, `CMI_R_OK, 5'h01);
		rchk(`CMI_A_NAME, 16'h4142);
		cmd(`CMI_C_NAME, n, `CMI_D_MODULES, 0, 0, `CMI_R_HDR, 0);
	endtask

	task automatic t_validity;
		client_u.wr(`CMI_A_PARAM, 16'd300);
		cmd(`CMI_C_VALID, `CMI_N_VALID, `CMI_D_VALID, 1, prof[95:64], `CMI_R_OK, 0);
		`CHK(valid_s, 9'h12c)
		client_u.wr(`CMI_A_PARAM, 16'd7);
		cmd(`CMI_C_VALID, `CMI_N_VALID, `CMI_D_VALID, 1, prof[31:0], `CMI_R_RANGE, 0);
		client_u.wr(`CMI_A_PARAM, 16'd5);
		cmd(`CMI_C_VALID, `CMI_N_VALID, `CMI_D_VALID, 1, 32'h11111111, `CMI_R_PW, 0);
		cmd(`CMI_C_VALID, `CMI_N_VALID, `CMI_D_VALID, 0, 0, `CMI_R_HDR, 0);
		cmd(`CMI_C_VALID, `CMI_N_VALID, `CMI_D_MODULES, 1, prof[31:0], `CMI_R_HDR, 0);
		cmd(`CMI_C_VALID, `CMI_N_VALID, `CMI_D_VALID, 1, prof[127:96], `CMI_R_OK, 0);
		`CHK(valid_s, 9'h005)
	endtask

	task automatic t_ext;
		cmd(`CMI_C_ALARM, 0, 0, 1, prof[31:0], `CMI_R_OK, 5'h10);
		cmd(`CMI_C_CRADLE, 0, 0, 1, prof[127:96], `CMI_R_OK, 5'h08);
		cmd(`CMI_C_REGREASE, 0, 0, 1, prof[31:0], `CMI_R_OK, 5'h04);
		cmd(`CMI_C_ALARM, 0, 0, 1, prof[95:64], `CMI_R_PW, 0);
		cmd(`CMI_C_EVENTS, 0, 0, 0, 0, `CMI_R_OK, 5'h02);
	endtask

	task automatic t_supply;
		lost = 1'b1;
		repeat (3) @(negedge i_clk);
		cmd(`CMI_C_GET_TIME, `CMI_N_GET_TIME, `CMI_D_MODULES, 0, 0, `CMI_R_OK, 0);
		rchk(`CMI_A_RES_MD, 16'h0101);
		rchk(`CMI_A_RES_YH, 16'h0000);
		rchk(`CMI_A_RES_MS, 16'h0000);
		rchk(`CMI_A_RES_MSEC, 16'h0000);
		lost = 1'b0;
	endtask

	initial begin
		repeat (6) @(negedge i_clk);
		i_rst_n = 1'b1;
		`CHK(valid_s, `CMI_V_DEF)
		t_get_time();
		t_set_time();
		t_name();
		t_validity();
		t_ext();
		t_supply();
		complete_run();
	end
endmodule

// File: verilog/cmi_cfg.svh
`ifndef CMI_CFG_SVH
`define CMI_CFG_SVH

// ****************************************
// Register word addresses
// ****************************************
`define CMI_A_CODE      16'h1f3f
`define CMI_A_COUNT     16'h1f40
`define CMI_A_DEST      16'h1f41
`define CMI_A_SEC       16'h1f42
`define CMI_A_PW_HI     16'h1f43
`define CMI_A_PW_LO     16'h1f44
`define CMI_A_PARAM     16'h1f45
`define CMI_PARAM_WORDS 27
`define CMI_A_RES_MD    16'h1f56
`define CMI_A_RES_YH    16'h1f57
`define CMI_A_RES_MS    16'h1f58
`define CMI_A_RES_MSEC  16'h1f59
`define CMI_A_STATUS    16'h1fd0
`define CMI_A_VALID     16'h1fd1
`define CMI_A_NAME      16'h2801
`define CMI_NAME_WORDS  24

// ****************************************
// Command codes and headers
// ****************************************
`define CMI_C_GET_TIME  16'h0300
`define CMI_C_SET_TIME  16'h0301
`define CMI_C_NAME      16'h0408
`define CMI_C_VALID     16'ha38c
`define CMI_C_ALARM     16'ha08b
`define CMI_C_CRADLE    16'ha188
`define CMI_C_REGREASE  16'ha189
`define CMI_C_EVENTS    16'hc580
`define CMI_N_GET_TIME  16'h000a
`define CMI_N_SET_TIME  16'h0012
`define CMI_N_VALID     16'h000c
`define CMI_N_NAME_MIN  16'h0007
`define CMI_N_NAME_MAX  16'h0035
`define CMI_N_NAME_HDR  16'h0007
`define CMI_D_MODULES   16'h2200
`define CMI_D_VALID     16'h2201
`define CMI_D_NAME      16'h0000
`define CMI_S_OPEN      16'h0000
`define CMI_S_PROFILE   16'h0001
`define CMI_P_NAME_0    16'h0104
`define CMI_P_NAME_1    16'h0081
`define CMI_P_NAME_2    16'h0800

// ****************************************
// Result codes, validity, profiles
// ****************************************
`define CMI_R_OK        8'h00
`define CMI_R_HDR       8'h01
`define CMI_R_PW        8'h02
`define CMI_R_UNKNOWN   8'h03
`define CMI_R_LOCKED    8'h04
`define CMI_R_RANGE     8'h05
`define CMI_V_MIN       9'h005
`define CMI_V_MAX       9'h12c
`define CMI_V_STEP      9'h005
`define CMI_V_DEF       9'h00a
`define CMI_PROF_ALL    4'hf
`define CMI_PROF_PRIV   4'h9

// ****************************************
// Time keeping
// ****************************************
`define CMI_CLK_NS      20
`define CMI_MS_NS       1000000
`define CMI_MS_MAX      16'h03e7
`define CMI_SEC_MAX     8'h3b
`define CMI_HOUR_MAX    8'h17
`define CMI_MONTH_MAX   8'h0c
`define CMI_YEAR_MAX    8'hff
`define CMI_T_ONE       8'h01

`endif

// File: verilog/cmi_command_unit.sv
// Notes on behaviour
// - Get time: code 768, count 10, dest 8704
// - Set time: code 769, count 18, dest 8704
// - Name write: code 1032, dest 0, 46 chars
// - Validity: 41868, count 12, 8705, security 1
// - Validity 5..300 s step 5, default 10
// - Result month/day, year-2000 in upper byte
// - Hour, minute/second, milliseconds result words
// - Front lock never blocks time commands
// - Supply loss restarts calendar at 2000-01-01
// - Extended codes; privileged except event retrieval
// - Validity and privileged extended codes need a profile password
`timescale 1ns/1ps
`include "cmi_cfg.svh"
module cmi_command_unit #(
	parameter int CYC_PER_MS = `CMI_MS_NS / `CMI_CLK_NS,
	parameter bit EXT_IFACE  = 1'b1
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic [15:0]       i_reg_addr,
	input  wire logic              i_reg_wr,
	input  wire logic              i_reg_rd,
	input  wire cmi_pkg::cmi_word_t i_reg_wdata,
	input  wire logic              i_front_lock,
	input  wire logic              i_supply_lost,
	input  wire logic [127:0]      i_profile_pw,
	output cmi_pkg::cmi_word_t     o_reg_rdata,
	output logic                   o_reg_ack,
	output logic                   o_busy,
	output logic [7:0]             o_result,
	output logic [8:0]             o_validity_s,
	output logic                   o_alarm_reset,
	output logic                   o_cradle_preset,
	output logic                   o_regrease_preset,
	output logic                   o_event_fetch,
	output logic                   o_name_written
);
	import cmi_pkg::*;

	if (CYC_PER_MS < 1) begin : g_chk
		$error("CYC_PER_MS must be at least one");
	end

	// ****************************************
	// Command block storage
	// ****************************************
	cmi_word_t  cmd_code;
	cmi_word_t  cmd_count;
	cmi_word_t  cmd_dest;
	cmi_word_t  cmd_sec;
	logic [31:0] cmd_pw;
	cmi_word_t  param_mem [`CMI_PARAM_WORDS];
	cmi_word_t  name_mem [`CMI_NAME_WORDS];
	cmi_word_t  res_md;
	cmi_word_t  res_yh;
	cmi_word_t  res_ms;
	cmi_word_t  res_msec;
	cmi_state_t state;
	cmi_op_t    op;
	cmi_time_t  now;
	cmi_time_t  set_time;
	cmi_word_t  pidx;
	cmi_word_t  nidx;
	cmi_word_t  next_rdata;
	cmi_word_t  name_end_word;
	cmi_word_t  name_nb;
	logic [7:0] next_result;
	logic [3:0] pw_hit;
	logic [3:0] pw_need;
	logic       start;
	logic       hdr_ok;
	logic       range_ok;
	logic       lock_ok;
	logic       run_ok;
	logic       p_in;
	logic [8:0] valid_in;

	assign start = i_reg_wr && (i_reg_addr == `CMI_A_CODE) && (state == CMI_IDLE);
	assign pidx  = i_reg_addr - `CMI_A_PARAM;
	assign nidx  = i_reg_addr - `CMI_A_NAME;
	assign p_in  = (i_reg_addr >= `CMI_A_PARAM) && (pidx < 16'(`CMI_PARAM_WORDS));

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cmd_code  <= '0;
			cmd_count <= '0;
			cmd_dest  <= '0;
			cmd_sec   <= '0;
			cmd_pw    <= '0;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`CMI_A_CODE:  cmd_code <= i_reg_wdata;
				`CMI_A_COUNT: cmd_count <= i_reg_wdata;
				`CMI_A_DEST:  cmd_dest <= i_reg_wdata;
				`CMI_A_SEC:   cmd_sec <= i_reg_wdata;
				`CMI_A_PW_HI: cmd_pw[31:16] <= i_reg_wdata;
				`CMI_A_PW_LO: cmd_pw[15:0] <= i_reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reg_wr && p_in)
			param_mem[pidx[4:0]] <= i_reg_wdata;
	end

	// ****************************************
	// Command decode
	// ****************************************
	always_comb begin
		op = CMI_OP_NONE;
		case (cmd_code)
			`CMI_C_GET_TIME: op = CMI_OP_GET_TIME;
			`CMI_C_SET_TIME: op = CMI_OP_SET_TIME;
			`CMI_C_NAME:     op = CMI_OP_NAME;
			`CMI_C_VALID:    op = CMI_OP_VALID;
			`CMI_C_ALARM:    if (EXT_IFACE) op = CMI_OP_ALARM;
			`CMI_C_CRADLE:   if (EXT_IFACE) op = CMI_OP_CRADLE;
			`CMI_C_REGREASE: if (EXT_IFACE) op = CMI_OP_REGREASE;
			`CMI_C_EVENTS:   if (EXT_IFACE) op = CMI_OP_EVENTS;
			default:         op = CMI_OP_NONE;
		endcase
	end

	// Name terminator position
	assign name_nb = cmd_count - `CMI_N_NAME_HDR;
	assign name_end_word = param_mem[5'(name_nb[5:1] + 5'h03)];

	always_comb begin
		hdr_ok = 1'b0;
		pw_need = 4'h0;
		case (op)
			CMI_OP_GET_TIME: hdr_ok = (cmd_count == `CMI_N_GET_TIME)
				&& (cmd_dest == `CMI_D_MODULES) && (cmd_sec == `CMI_S_OPEN);
			CMI_OP_SET_TIME: hdr_ok = (cmd_count == `CMI_N_SET_TIME)
				&& (cmd_dest == `CMI_D_MODULES) && (cmd_sec == `CMI_S_OPEN);
			CMI_OP_NAME: hdr_ok = (cmd_count >= `CMI_N_NAME_MIN)
				&& (cmd_count <= `CMI_N_NAME_MAX) && (cmd_dest == `CMI_D_NAME)
				&& (cmd_sec == `CMI_S_OPEN);
			CMI_OP_VALID: begin
				hdr_ok = (cmd_count == `CMI_N_VALID) && (cmd_dest == `CMI_D_VALID)
					&& (cmd_sec == `CMI_S_PROFILE);
				pw_need = `CMI_PROF_ALL;
			end
			CMI_OP_ALARM, CMI_OP_CRADLE, CMI_OP_REGREASE: begin
				hdr_ok = (cmd_sec == `CMI_S_PROFILE);
				pw_need = `CMI_PROF_PRIV;
			end
			CMI_OP_EVENTS: hdr_ok = (cmd_sec == `CMI_S_OPEN);
			default: hdr_ok = 1'b0;
		endcase
	end

	// Profile password match, one comparator per profile
	for (genvar p = 0; p < 4; p++) begin : g_pw
		assign pw_hit[p] = (cmd_pw != 32'h0) && (cmd_pw == i_profile_pw[p*32 +: 32]);
	end

	assign valid_in = param_mem[0][8:0];
	assign set_time = '{month: param_mem[0][15:8], day: param_mem[0][7:0],
		year: param_mem[1][15:8], hour: param_mem[1][7:0],
		minute: param_mem[2][15:8], second: param_mem[2][7:0], msec: param_mem[3]};

	always_comb begin
		case (op)
			CMI_OP_SET_TIME: range_ok = (set_time.month >= `CMI_T_ONE)
				&& (set_time.month <= `CMI_MONTH_MAX) && (set_time.day >= `CMI_T_ONE)
				&& (set_time.day <= 8'h1f) && (set_time.hour <= `CMI_HOUR_MAX)
				&& (set_time.minute <= `CMI_SEC_MAX) && (set_time.second <= `CMI_SEC_MAX)
				&& (set_time.msec <= `CMI_MS_MAX);
			CMI_OP_NAME: range_ok = (param_mem[0] == `CMI_P_NAME_0)
				&& (param_mem[1] == `CMI_P_NAME_1) && (param_mem[2] == `CMI_P_NAME_2)
				&& ((name_nb[0] ? name_end_word[7:0] : name_end_word[15:8]) == 8'h00);
			CMI_OP_VALID: range_ok = (param_mem[0][15:9] == 7'h00)
				&& (valid_in >= `CMI_V_MIN) && (valid_in <= `CMI_V_MAX)
				&& (valid_in % `CMI_V_STEP == 9'h000);
			default: range_ok = 1'b1;
		endcase
	end

	// Lock holds back writing commands only; time commands pass
	assign lock_ok = !i_front_lock || (op == CMI_OP_GET_TIME)
		|| (op == CMI_OP_SET_TIME) || (op == CMI_OP_EVENTS);

	always_comb begin
		if (op == CMI_OP_NONE)
			next_result = `CMI_R_UNKNOWN;
		else if (!hdr_ok)
			next_result = `CMI_R_HDR;
		else if ((pw_need != 4'h0) && ((pw_hit & pw_need) == 4'h0))
			next_result = `CMI_R_PW;
		else if (!lock_ok)
			next_result = `CMI_R_LOCKED;
		else if (!range_ok)
			next_result = `CMI_R_RANGE;
		else
			next_result = `CMI_R_OK;
	end

	assign run_ok = (state == CMI_RUN) && (next_result == `CMI_R_OK);

	// ****************************************
	// Execution sequence
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state    <= CMI_IDLE;
			o_busy   <= 1'b0;
			o_result <= `CMI_R_OK;
		end else begin
			case (state)
				CMI_IDLE: begin
					if (start) begin
						state  <= CMI_RUN;
						o_busy <= 1'b1;
					end
				end
				CMI_RUN: begin
					state    <= CMI_IDLE;
					o_busy   <= 1'b0;
					o_result <= next_result;
				end
				default: begin
					state  <= CMI_IDLE;
					o_busy <= 1'b0;
				end
			endcase
		end
	end

	cmi_time_keeper #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_time (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_clear     (i_supply_lost),
		.i_load      (run_ok && (op == CMI_OP_SET_TIME)),
		.i_load_time (set_time),
		.o_time      (now)
	);

	// Time result words
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			res_md   <= '0;
			res_yh   <= '0;
			res_ms   <= '0;
			res_msec <= '0;
		end else if (run_ok && (op == CMI_OP_GET_TIME)) begin
			res_md   <= {now.month, now.day};
			res_yh   <= {now.year, now.hour};
			res_ms   <= {now.minute, now.second};
			res_msec <= now.msec;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n)
			o_validity_s <= `CMI_V_DEF;
		else if (run_ok && (op == CMI_OP_VALID))
			o_validity_s <= valid_in;
	end

	// Name copy, one word per entry
	for (genvar n = 0; n < `CMI_NAME_WORDS; n++) begin : g_name
		always_ff @(posedge i_clk) begin
			if (!i_rst_n)
				name_mem[n] <= '0;
			else if (run_ok && (op == CMI_OP_NAME))
				name_mem[n] <= param_mem[n + 3];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_alarm_reset     <= 1'b0;
			o_cradle_preset   <= 1'b0;
			o_regrease_preset <= 1'b0;
			o_event_fetch     <= 1'b0;
			o_name_written    <= 1'b0;
		end else begin
			o_alarm_reset     <= run_ok && (op == CMI_OP_ALARM);
			o_cradle_preset   <= run_ok && (op == CMI_OP_CRADLE);
			o_regrease_preset <= run_ok && (op == CMI_OP_REGREASE);
			o_event_fetch     <= run_ok && (op == CMI_OP_EVENTS);
			o_name_written    <= run_ok && (op == CMI_OP_NAME);
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	always_comb begin
		next_rdata = 16'h0000;
		case (i_reg_addr)
			`CMI_A_CODE:     next_rdata = cmd_code;
			`CMI_A_COUNT:    next_rdata = cmd_count;
			`CMI_A_DEST:     next_rdata = cmd_dest;
			`CMI_A_SEC:      next_rdata = cmd_sec;
			`CMI_A_PW_HI:    next_rdata = cmd_pw[31:16];
			`CMI_A_PW_LO:    next_rdata = cmd_pw[15:0];
			`CMI_A_RES_MD:   next_rdata = res_md;
			`CMI_A_RES_YH:   next_rdata = res_yh;
			`CMI_A_RES_MS:   next_rdata = res_ms;
			`CMI_A_RES_MSEC: next_rdata = res_msec;
			`CMI_A_STATUS:   next_rdata = {o_busy, 7'h00, o_result};
			`CMI_A_VALID:    next_rdata = {7'h00, o_validity_s};
			default: begin
				if (p_in)
					next_rdata = param_mem[pidx[4:0]];
				else if ((i_reg_addr >= `CMI_A_NAME) && (nidx < 16'(`CMI_NAME_WORDS)))
					next_rdata = name_mem[nidx[4:0]];
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= '0;
			o_reg_ack   <= 1'b0;
		end else begin
			o_reg_ack <= i_reg_rd || i_reg_wr;
			if (i_reg_rd)
				o_reg_rdata <= next_rdata;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_valid_default: assert property ($past(!i_rst_n) |-> o_validity_s == 9'h00a)
		else $error("validity not at default after reset");
	a_valid_bounds: assert property (o_validity_s >= 9'h005 && o_validity_s <= 9'h12c
		&& o_validity_s % 9'h005 == 9'h000)
		else $error("validity out of range");
	a_get_hdr: assert property (state == CMI_RUN && cmd_code == 16'h0300
		&& cmd_count == 16'h000a && cmd_dest == 16'h2200 && cmd_sec == 16'h0000
		|=> o_result == 8'h00)
		else $error("valid time read refused");
	a_set_hdr: assert property (state == CMI_RUN && cmd_code == 16'h0301
		&& cmd_count != 16'h0012 |=> o_result == 8'h01)
		else $error("bad set time count accepted");
	a_md_result: assert property (run_ok && op == CMI_OP_GET_TIME
		|=> res_md == {$past(now.month), $past(now.day)} && res_yh[15:8] == $past(now.year))
		else $error("month day year result wrong");
	a_ms_result: assert property (run_ok && op == CMI_OP_GET_TIME
		|=> res_ms == {$past(now.minute), $past(now.second)} && res_msec == $past(now.msec))
		else $error("minute second result wrong");
	a_lock_pass: assert property (state == CMI_RUN && i_front_lock
		&& (op == CMI_OP_GET_TIME || op == CMI_OP_SET_TIME) |=> o_result != 8'h04)
		else $error("lock blocked a time command");
	a_valid_pw: assert property (state == CMI_RUN && op == CMI_OP_VALID
		&& pw_hit == 4'h0 |=> o_result != 8'h00 && $stable(o_validity_s))
		else $error("validity set without password");
	a_valid_hdr: assert property (state == CMI_RUN && op == CMI_OP_VALID
		&& cmd_dest != 16'h2201 |=> o_result == 8'h01)
		else $error("bad validity destination accepted");
	a_alarm_pulse: assert property (run_ok && op == CMI_OP_ALARM
		|=> o_alarm_reset ##1 !o_alarm_reset)
		else $error("alarm reset pulse wrong");
	a_name_copy: assert property (run_ok && op == CMI_OP_NAME
		|=> name_mem[0] == $past(param_mem[3]) && o_name_written)
		else $error("name not stored");
	a_busy_pulse: assert property (start |=> o_busy ##1 !o_busy)
		else $error("busy not one cycle");

endmodule

// File: verilog/cmi_pkg.sv
package cmi_pkg;

	typedef logic [15:0] cmi_word_t;

	typedef enum logic [1:0] {
		CMI_IDLE,
		CMI_RUN
	} cmi_state_t;

	typedef enum logic [3:0] {
		CMI_OP_NONE,
		CMI_OP_GET_TIME,
		CMI_OP_SET_TIME,
		CMI_OP_NAME,
		CMI_OP_VALID,
		CMI_OP_ALARM,
		CMI_OP_CRADLE,
		CMI_OP_REGREASE,
		CMI_OP_EVENTS
	} cmi_op_t;

	typedef struct packed {
		logic [7:0]  month;
		logic [7:0]  day;
		logic [7:0]  year;
		logic [7:0]  hour;
		logic [7:0]  minute;
		logic [7:0]  second;
		logic [15:0] msec;
	} cmi_time_t;

endpackage

// File: verilog/cmi_time_keeper.sv
`timescale 1ns/1ps
`include "cmi_cfg.svh"
module cmi_time_keeper #(
	parameter int CYC_PER_MS = `CMI_MS_NS / `CMI_CLK_NS
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_clear,
	input  wire logic              i_load,
	input  wire cmi_pkg::cmi_time_t i_load_time,
	output cmi_pkg::cmi_time_t     o_time
);
	import cmi_pkg::*;

	localparam int CW = $clog2(CYC_PER_MS + 1);

	if (CYC_PER_MS < 1) begin : g_chk
		$error("CYC_PER_MS must be at least one");
	end

	localparam cmi_time_t T_ORIGIN = '{
		month: `CMI_T_ONE, day: `CMI_T_ONE, year: 8'h00, hour: 8'h00,
		minute: 8'h00, second: 8'h00, msec: 16'h0000};

	logic [CW-1:0] cyc;
	logic          tick;
	logic [7:0]    mdays;

	assign tick = (cyc == CW'(CYC_PER_MS - 1));

	// ****************************************
	// Days in the current month
	// ****************************************
	always_comb begin
		case (o_time.month)
			8'h02:   mdays = (o_time.year[1:0] == 2'h0) ? 8'h1d : 8'h1c;
			8'h04, 8'h06, 8'h09, 8'h0b: mdays = 8'h1e;
			default: mdays = 8'h1f;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_load || tick)
			cyc <= '0;
		else
			cyc <= cyc + CW'(1);
	end

	// ****************************************
	// Calendar cascade
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_clear) begin
			o_time <= T_ORIGIN;
		end else if (i_load) begin
			o_time <= i_load_time;
		end else if (tick) begin
			o_time.msec <= o_time.msec + 16'h0001;
			if (o_time.msec == `CMI_MS_MAX) begin
				o_time.msec <= 16'h0000;
				o_time.second <= o_time.second + 8'h01;
				if (o_time.second == `CMI_SEC_MAX) begin
					o_time.second <= 8'h00;
					o_time.minute <= o_time.minute + 8'h01;
					if (o_time.minute == `CMI_SEC_MAX) begin
						o_time.minute <= 8'h00;
						o_time.hour <= o_time.hour + 8'h01;
						if (o_time.hour == `CMI_HOUR_MAX) begin
							o_time.hour <= 8'h00;
							o_time.day <= o_time.day + 8'h01;
							if (o_time.day >= mdays) begin
								o_time.day <= `CMI_T_ONE;
								o_time.month <= o_time.month + 8'h01;
								if (o_time.month >= `CMI_MONTH_MAX) begin
									o_time.month <= `CMI_T_ONE;
									o_time.year <= o_time.year + 8'h01;
								end
							end
						end
					end
				end
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_clear_origin: assert property (i_clear |=> o_time == T_ORIGIN)
		else $error("time not at origin after supply loss");

endmodule

// File: verilog/cmi_time_keeper_unused_marker.sv
`timescale 1ns/1ps
